// ### idmt_divider.sv
`timescale 1ns/1ns
module idmt_divider #(
  parameter int NW = 28,
  parameter int DW = 16
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rstn,
  // request
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  // result
  output logic      [NW-1:0] quot,
  output logic               done
);

  // ****************************************************************
  // restoring division, one quotient bit per clock
  // ****************************************************************
  logic [NW-1:0] num_q;
  logic [DW:0]   rem_q;
  logic [DW-1:0] den_q;
  logic [5:0]    cnt_q;
  logic          busy_q;
  logic [DW:0]   trial;
  logic          fits;

  assign trial = {rem_q[DW-1:0], num_q[NW-1]};
  assign fits  = trial >= {1'b0, den_q};

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      num_q  <= '0;
      rem_q  <= '0;
      den_q  <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      quot   <= '0;
      done   <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy_q)
      begin
        num_q  <= num;
        den_q  <= den;
        rem_q  <= '0;
        cnt_q  <= 6'(NW);
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        rem_q  <= fits ? trial - {1'b0, den_q} : trial;
        num_q  <= {num_q[NW-2:0], fits};
        cnt_q  <= cnt_q - 6'h01;
        if (cnt_q == 6'h01)
        begin
          busy_q <= 1'b0;
          done   <= 1'b1;
          quot   <= {num_q[NW-2:0], fits};
        end
      end
    end
  end

endmodule : idmt_divider

// ### idmt_overcurrent.sv
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ns
// Function
// - trip time equals multiplier over square of (current ratio minus one).
// - multiplier equals the trip time at twice the limit.
// - the current used is that of the most loaded phase.
// - at or below the limit the protection never trips.
// - beyond a current ceiling the trip time stays at its minimum.
// - heat of an earlier non-tripping overload shortens the next trip.
// - three limits; the selected group picks the limit used.
// - a setting picks load-dump or shutdown alarm on trip.
// - multiplier 36 gives 3600 s, 36 s, 9 s at 110, 200, 300 %.
module idmt_overcurrent
  import idmt_pkg::*;
#(
  parameter int IW       = 16,
  parameter int TICK_CYC = IDMT_TICK_CYC
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rstn,
  // phase currents
  input  wire logic [IW-1:0] cur_l1,
  input  wire logic [IW-1:0] cur_l2,
  input  wire logic [IW-1:0] cur_l3,
  // register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  // alarms
  output logic               loaddump_alarm_q,
  output logic               shutdown_alarm_q
);

  localparam int NW = IW + IDMT_FRAC;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [3:0]            ctrl_q;
  logic [IW-1:0]         lim_q [3];
  logic [15:0]           tms_q;
  logic                  trip_q;
  logic                  over_q;
  logic [IDMT_ACC_W-1:0] acc_q;
  logic [31:0]           tick_q;
  logic [IW-1:0]         imax_q;
  logic [IW-1:0]         iset_q;
  logic [15:0]           q_q;
  idmt_state_e           state_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  // ****************************************************************
  // selection and arithmetic
  // ****************************************************************
  logic [IW-1:0]         max12;
  logic [IW-1:0]         imax;
  logic [IW-1:0]         iset;
  logic [1:0]            grp;
  logic                  tick;
  logic                  above;
  logic [NW-1:0]         div_num;
  logic [NW-1:0]         div_quot;
  logic                  div_done;
  logic [15:0]           q_clamp;
  logic [31:0]           q_sq;
  logic [IDMT_ACC_W-1:0] acc_sum;
  logic [IDMT_ACC_W-1:0] trip_lvl;
  logic [IDMT_ACC_W-1:0] acc_decay;
  logic                  ack_wr;
  logic                  div_go;

  assign max12   = (cur_l1 > cur_l2) ? cur_l1 : cur_l2;
  assign imax    = (max12 > cur_l3) ? max12 : cur_l3;
  // group selects limit, unused code falls back to primary
  assign grp     = ctrl_q[IDMT_CTRL_GRP_LSB +: 2];
  assign iset    = (grp == IDMT_GRP_SEC) ? lim_q[1] :
                   (grp == IDMT_GRP_TER) ? lim_q[2] : lim_q[0];
  assign tick    = (tick_q == 32'(TICK_CYC - 1));
  assign above   = ctrl_q[IDMT_CTRL_EN_BIT] && (iset_q != '0)
                   && (imax_q > iset_q);
  assign div_num = NW'({imax_q - iset_q, {IDMT_FRAC{1'b0}}});
  // excess ratio clamped, fixing the minimum trip time
  assign q_clamp = (div_quot > NW'(IDMT_QMAX)) ? IDMT_QMAX
                                                : div_quot[15:0];
  // heat per second is the squared excess ratio
  assign q_sq    = q_q * q_q;
  // heat adds onto residual from earlier overloads
  assign acc_sum = acc_q + IDMT_ACC_W'(q_sq);
  // trip once the sum reaches multiplier seconds at unit ratio
  // 36 s multiplier, ratio 0.1 squared, gives 3600 ticks
  assign trip_lvl = IDMT_ACC_W'({tms_q, {(2*IDMT_FRAC){1'b0}}});
  // geometric cool-down while below the limit
  assign acc_decay = acc_q - (acc_q >> IDMT_DECAY_SH);
  assign ack_wr    = reg_wr && hit(reg_addr, IDMT_ACK_ADDR)
                     && reg_wdata[IDMT_STAT_TRIP];

  // drop start on done, else the divider reruns while idle
  assign div_go    = (state_q == IDMT_DIV) && !div_done;

  idmt_divider #(
    .NW (NW),
    .DW (IW)
  ) u_div (
    .mclk  (mclk),
    .rstn  (rstn),
    .start (div_go),
    .num   (div_num),
    .den   (iset_q),
    .quot  (div_quot),
    .done  (div_done)
  );

  // ****************************************************************
  // one-second evaluation sequence
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      tick_q  <= '0;
      state_q <= IDMT_IDLE;
      imax_q  <= '0;
      iset_q  <= '0;
      q_q     <= '0;
      over_q  <= 1'b0;
      acc_q   <= '0;
    end
    else
    begin
      tick_q <= tick ? '0 : tick_q + 32'h1;
      case (state_q)
        IDMT_IDLE:
        begin
          if (tick)
          begin
            imax_q  <= imax;
            iset_q  <= iset;
            state_q <= IDMT_ACC;
          end
        end
        IDMT_ACC:
        begin
          over_q <= above;
          if (above)
            state_q <= IDMT_DIV;
          else
          begin
            acc_q   <= acc_decay;
            state_q <= IDMT_IDLE;
          end
        end
        IDMT_DIV:
        begin
          if (div_done)
          begin
            q_q     <= q_clamp;
            state_q <= IDMT_IDLE;
          end
        end
        default: state_q <= IDMT_IDLE;
      endcase
      // heat added one cycle after the quotient lands
      if (state_q == IDMT_IDLE && q_q != '0)
        acc_q <= (acc_sum > trip_lvl) ? trip_lvl : acc_sum;
      if (state_q == IDMT_IDLE && q_q != '0)
        q_q <= '0;
    end
  end

  // ****************************************************************
  // trip latch and alarms
  // ****************************************************************
  logic trip_now;
  assign trip_now = (acc_q >= trip_lvl) && (tms_q != '0) && over_q;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      trip_q           <= 1'b0;
      loaddump_alarm_q <= 1'b0;
      shutdown_alarm_q <= 1'b0;
    end
    else if (trip_now && !trip_q)
    begin
      trip_q           <= 1'b1;
      loaddump_alarm_q <= !ctrl_q[IDMT_CTRL_ACT_BIT];
      shutdown_alarm_q <= ctrl_q[IDMT_CTRL_ACT_BIT];
    end
    else if (ack_wr)
    begin
      trip_q           <= 1'b0;
      loaddump_alarm_q <= 1'b0;
      shutdown_alarm_q <= 1'b0;
    end
  end

  // ****************************************************************
  // register port
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ctrl_q <= IDMT_CTRL_RST;
      lim_q  <= '{default: IW'(IDMT_LIM_RST)};
      tms_q  <= IDMT_TMS_RST;
    end
    else if (reg_wr)
    begin
      if (hit(reg_addr, IDMT_CTRL_ADDR))
        ctrl_q <= reg_wdata[3:0];
      if (hit(reg_addr, IDMT_LIMP_ADDR))
        lim_q[0] <= reg_wdata[IW-1:0];
      if (hit(reg_addr, IDMT_LIMS_ADDR))
        lim_q[1] <= reg_wdata[IW-1:0];
      if (hit(reg_addr, IDMT_LIMT_ADDR))
        lim_q[2] <= reg_wdata[IW-1:0];
      if (hit(reg_addr, IDMT_TMS_ADDR))
        tms_q <= reg_wdata[15:0];
    end
  end

  logic [31:0] rd_mux;
  assign rd_mux =
    hit(reg_addr, IDMT_CTRL_ADDR) ? {28'h0, ctrl_q} :
    hit(reg_addr, IDMT_LIMP_ADDR) ? 32'(lim_q[0]) :
    hit(reg_addr, IDMT_LIMS_ADDR) ? 32'(lim_q[1]) :
    hit(reg_addr, IDMT_LIMT_ADDR) ? 32'(lim_q[2]) :
    hit(reg_addr, IDMT_TMS_ADDR)  ? {16'h0, tms_q} :
    hit(reg_addr, IDMT_STAT_ADDR) ? {28'h0, over_q, shutdown_alarm_q,
                                     loaddump_alarm_q, trip_q} :
    hit(reg_addr, IDMT_HEAT_ADDR) ? acc_q[IDMT_ACC_W-1 -: 32] :
    32'h0;

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_rd ? rd_mux : '0;
  end

endmodule : idmt_overcurrent

// ### idmt_overcurrent_props.sv
`timescale 1ns/1ns
module idmt_overcurrent_props
  import idmt_pkg::*;
#(
  parameter int TICK_CYC = 100
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // alarms
  input wire logic        loaddump_alarm_q,
  input wire logic        shutdown_alarm_q
);
  logic act_q;
  wire  alm = loaddump_alarm_q | shutdown_alarm_q;
  wire  ack = reg_wr && reg_addr == IDMT_ACK_ADDR && reg_wdata[0];
  wire  cwr = reg_wr && reg_addr == IDMT_CTRL_ADDR;

  // copy of the action bit, as the alarm picks it at trip time
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      act_q <= 1'b0;
    else if (cwr)
      act_q <= reg_wdata[IDMT_CTRL_ACT_BIT];
  end

  // ****
  // properties
  // ****
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence ack_s;
    ack;
  endsequence
  sequence clr_s;
    ##[1:2] !alm;
  endsequence

  AST_ONE_ACTION: assert property (
    !(loaddump_alarm_q && shutdown_alarm_q))
    else $error("both alarms high");
  AST_QUIET_AFTER_RESET: assert property ($rose(rstn) |-> !alm)
    else $error("alarm after reset");
  AST_LD_LATCH: assert property (
    loaddump_alarm_q && !ack |=> loaddump_alarm_q)
    else $error("load-dump alarm dropped");
  AST_SD_LATCH: assert property (
    shutdown_alarm_q && !ack |=> shutdown_alarm_q)
    else $error("shutdown alarm dropped");
  AST_ACK_CLEARS: assert property (ack_s |-> clr_s)
    else $error("acknowledge left alarm");
  AST_LD_ACTION: assert property (
    $rose(loaddump_alarm_q) |-> !$past(act_q))
    else $error("load-dump with shutdown action");
  AST_SD_ACTION: assert property (
    $rose(shutdown_alarm_q) |-> $past(act_q))
    else $error("shutdown with load-dump action");
  AST_STAT_ALARMS: assert property (
    reg_rd && reg_addr == IDMT_STAT_ADDR |=> reg_rdata[2:0] ==
    {$past(shutdown_alarm_q), $past(loaddump_alarm_q), $past(alm)})
    else $error("status disagrees with alarms");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data without read");
endmodule : idmt_overcurrent_props

bind idmt_overcurrent idmt_overcurrent_props #(
  .TICK_CYC (TICK_CYC)
) idmt_overcurrent_props_i (
  .mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .loaddump_alarm_q, .shutdown_alarm_q
);

// ### idmt_phase_src.sv
`timescale 1ns/1ns
module idmt_phase_src (
  // commanded load: phase hot (0 to 2) at peak, the rest at base
  input  wire logic [15:0] peak,
  input  wire logic [15:0] base,
  input  wire logic [1:0]  hot,
  // measured phase magnitudes
  output logic      [15:0] cur_l1,
  output logic      [15:0] cur_l2,
  output logic      [15:0] cur_l3
);
  assign cur_l1 = (hot == 2'h0) ? peak : base;
  assign cur_l2 = (hot == 2'h1) ? peak : base;
  assign cur_l3 = (hot == 2'h2) ? peak : base;
endmodule : idmt_phase_src

// ### idmt_pkg.sv
package idmt_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] IDMT_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] IDMT_LIMP_ADDR   = 8'h04;
  localparam logic [7:0] IDMT_LIMS_ADDR   = 8'h08;
  localparam logic [7:0] IDMT_LIMT_ADDR   = 8'h0C;
  localparam logic [7:0] IDMT_TMS_ADDR    = 8'h10;
  localparam logic [7:0] IDMT_STAT_ADDR   = 8'h14;
  localparam logic [7:0] IDMT_ACK_ADDR    = 8'h18;
  localparam logic [7:0] IDMT_HEAT_ADDR   = 8'h1C;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          IDMT_CTRL_GRP_LSB = 0;
  localparam int          IDMT_CTRL_ACT_BIT = 2;
  localparam int          IDMT_CTRL_EN_BIT  = 3;
  localparam int          IDMT_STAT_TRIP    = 0;
  localparam int          IDMT_STAT_LD      = 1;
  localparam int          IDMT_STAT_SD      = 2;
  localparam int          IDMT_STAT_OVER    = 3;
  localparam logic [3:0]  IDMT_CTRL_RST     = 4'h8;
  localparam logic [15:0] IDMT_LIM_RST      = 16'h03E8;
  localparam logic [15:0] IDMT_TMS_RST      = 16'h0024;

  // setting groups
  localparam logic [1:0]  IDMT_GRP_PRI      = 2'h0;
  localparam logic [1:0]  IDMT_GRP_SEC      = 2'h1;
  localparam logic [1:0]  IDMT_GRP_TER      = 2'h2;

  // ****************************************************************
  // arithmetic and timing
  // ****************************************************************
  localparam int          IDMT_FRAC         = 12;
  localparam int          IDMT_ACC_W        = 48;
  // ratio excess clamp 2.0 (300 % load): definite minimum time tms/4
  localparam logic [15:0] IDMT_QMAX         = 16'h2000;
  localparam int          IDMT_DECAY_SH     = 6;
  localparam longint      IDMT_CLK_HZ       = 50000000;
  localparam longint      IDMT_TICK_S       = 1;
  localparam int          IDMT_TICK_CYC     = int'(IDMT_CLK_HZ * IDMT_TICK_S);

  typedef enum logic [1:0] {IDMT_IDLE, IDMT_DIV, IDMT_ACC} idmt_state_e;

endpackage : idmt_pkg

// ### test_idmt_overcurrent_protection.sv
`timescale 1ns/1ns
module test_idmt_overcurrent_protection
  import idmt_pkg::*;
;
  localparam int T = 100;
  logic        mclk, rstn, reg_wr, reg_rd;
  logic        loaddump_alarm_q, shutdown_alarm_q;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] peak, base, cur_l1, cur_l2, cur_l3;
  logic [1:0]  hot;
  int          errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic [31:0] rv [9] = '{32'h8, 32'h3E8, 32'h3E8, 32'h3E8, 32'h24,
                          32'h0, 32'h0, 32'h0, 32'h0};

  idmt_phase_src idmt_phase_src_i (
    .peak, .base, .hot, .cur_l1, .cur_l2, .cur_l3
  );
  idmt_overcurrent #(
    .TICK_CYC (T)
  ) idmt_overcurrent_i (
    .mclk, .rstn, .cur_l1, .cur_l2, .cur_l3, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .loaddump_alarm_q, .shutdown_alarm_q
  );

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task summarize;
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // runaway guard, more than twice the planned run
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      errors++;
      summarize;
    end
  end

  // ****
  // access tasks
  // ****
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), reg_rdata, e);
    @(posedge mclk);
  endtask : rd

  task alm(input logic [1:0] e);
    #1;
    chk("alarms", {30'h0, shutdown_alarm_q, loaddump_alarm_q}, {30'h0, e});
    // realign so the next driver changes right after an edge
    @(posedge mclk);
  endtask : alm

  task tk(input int n);
    repeat (n * T) @(posedge mclk);
  endtask : tk

  task rst;
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
  endtask : rst

  // one overload on phase p, group g with limit l, expecting n ticks
  task trip(input logic [1:0] g, input logic a, input logic [1:0] p,
            input logic [15:0] k, input logic [15:0] l, input int n);
    rst;
    peak <= k;
    hot <= p;
    // idle phases above a 500 limit but below peak: only max trips in time
    base <= 16'h02EE;
    wr(IDMT_LIMP_ADDR + {4'h0, g, 2'h0}, {16'h0, l});
    rd(IDMT_LIMP_ADDR + {4'h0, g, 2'h0}, {16'h0, l});
    wr(IDMT_CTRL_ADDR, {28'h0, 1'b1, a, g});
    tk(n - 1);
    repeat (T / 2) @(posedge mclk);
    alm(2'h0);
    tk(1);
    alm(a ? 2'h2 : 2'h1);
    rd(IDMT_STAT_ADDR, {28'h0, 1'b1, a, ~a, 1'b1});
    rd(IDMT_HEAT_ADDR, 32'h2400);
  endtask : trip

  initial
  begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {peak, base, hot} = '0;
    rst;
    peak <= 16'h03E8;
    for (int i = 0; i < 9; i++)
      rd(8'(4 * i), rv[i]);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    tk(40);
    alm(2'h0);
    rd(IDMT_STAT_ADDR, 32'h0);
    for (int g = 0; g < 3; g++)
      trip(2'(g), g[0], 2'(g), 16'h03E8, 16'h01F4, 36);
    trip(2'h0, 1'b1, 2'h2, 16'h0BB8, 16'h03E8, 9);
    trip(2'h0, 1'b0, 2'h1, 16'h1194, 16'h03E8, 9);
    rst;
    peak <= 16'h07D0;
    tk(20);
    repeat (T / 2) @(posedge mclk);
    rd(IDMT_HEAT_ADDR, 32'h1400);
    peak <= 16'h0064;
    tk(1);
    rd(IDMT_HEAT_ADDR, 32'h13B0);
    peak <= 16'h07D0;
    tk(20);
    alm(2'h1);
    peak <= 16'h0000;
    tk(2);
    alm(2'h1);
    rd(IDMT_STAT_ADDR, 32'h3);
    wr(IDMT_ACK_ADDR, 32'h0);
    alm(2'h1);
    wr(IDMT_ACK_ADDR, 32'h1);
    alm(2'h0);
    rd(IDMT_STAT_ADDR, 32'h0);
    summarize;
  end
endmodule : test_idmt_overcurrent_protection
